// [hw/fmgb_unit.sv]
// Flow table miss handling, group table, action buckets and table counters.
// Assumes lookup results arrive on clk and the bucket consumer may stall.
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "fmgb_params.svh"
// Notes on behaviour
// - Ingress miss: drop, trap, next, execute set.
// - Egress miss: zero forwards, one drops.
// - Trap bit six picks local or master.
// - Execute set stops pipeline, runs actions.
// - Group table: 2048 entries of type, count, first.
// - Bucket count reaches up to 128 buckets.
// - All group runs every bucket in range.
// - Select group runs one hashed bucket.
// - No failover type; indirect is All of one.
// - Hash uses only inputs whose bit is set.
// - Absent hash inputs count as zero.
// - Bucket table: 8192 entries of edit actions.
// - Pop depth bit: one or two labels.
// - Push ethertype bit: 8847 or 8848.
// - Push method one uses encapsulation index.
// - Field edits hit the outermost matching header.
// - Slot a kinds zero to seven.
// - Slot d rewrites source or destination IPv4.
// - Slot e rewrites source or destination port.
// - Output types zero to ten only.
// - Lookup and match counts clear on read.
module fmgb_unit (
  input  wire logic                  clk,           // 10 MHz clock.
  input  wire logic                  rstn,          // Asynchronous reset, active low.
  input  wire logic [7:0]            address,       // Avalon byte address.
  input  wire logic                  read,          // Avalon read.
  input  wire logic                  write,         // Avalon write.
  input  wire logic [31:0]           writedata,     // Avalon write data.
  input  wire logic [3:0]            byteenable,    // Avalon byte enables.
  output logic      [31:0]           readdata,      // Avalon read data.
  output logic                       waitrequest,   // Avalon wait.
  input  wire logic                  lkp_valid,     // One lookup result this cycle.
  input  wire fmgb_pkg::fmgb_lookup_t lkp,          // Lookup result.
  output logic                       miss_valid,    // Miss decision pulse.
  output fmgb_pkg::fmgb_fate_t       miss_fate,     // What to do with the missed packet.
  output logic                       stop_pipeline, // Stop lookups, run action set.
  input  wire logic                  grp_valid,     // Group request.
  input  wire logic [10:0]           grp_index,     // Group entry number.
  input  wire fmgb_pkg::fmgb_hkey_t  grp_key,       // Hash inputs of the packet.
  output logic                       grp_ready,     // Group request accepted.
  output logic                       bkt_valid,     // Bucket on offer.
  output fmgb_pkg::fmgb_bucket_t     bkt,           // Decoded bucket.
  output logic                       bkt_last,      // Last bucket of the group.
  input  wire logic                  bkt_ready      // Consumer takes the bucket.
);
  // Byte-enable merge, used by the table index and bucket word registers.
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        o[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return o;
  endfunction

  // Sixteen-bit fold of the selected, present hash inputs.
  function automatic logic [15:0] fold(input fmgb_pkg::fmgb_hkey_t k, input logic [6:0] sel);
    logic [6:0]  u;
    logic [15:0] h;
    u = sel & k.present;
    h = 16'h0000;
    if (u[0]) h ^= k.l4_dport;
    if (u[1]) h ^= k.l4_sport;
    if (u[2]) h ^= k.dip[31:16] ^ k.dip[15:0];
    if (u[3]) h ^= k.sip[31:16] ^ k.sip[15:0];
    if (u[4]) h ^= k.dmac[47:32] ^ k.dmac[31:16] ^ k.dmac[15:0];
    if (u[5]) h ^= k.smac[47:32] ^ k.smac[31:16] ^ k.smac[15:0];
    if (u[6]) h ^= {10'h000, k.port};
    return h;
  endfunction

  logic [1:0]  igr_miss_q [`FMGB_IGR_TBLS];
  logic [1:0]  igr_miss_d [`FMGB_IGR_TBLS];
  logic [31:0] ilk_q [`FMGB_IGR_TBLS];
  logic [31:0] ilk_d [`FMGB_IGR_TBLS];
  logic [31:0] imt_q [`FMGB_IGR_TBLS];
  logic [31:0] imt_d [`FMGB_IGR_TBLS];
  logic        egr_miss_q, egr_miss_d, trap_q, trap_d, ack_q, ack_d;
  logic [6:0]  hsel_q, hsel_d;
  logic [12:0] tidx_q, tidx_d;
  logic [31:0] elk_q, elk_d, emt_q, emt_d, rd_q, rd_d;
  logic [21:0] grp_mem [`FMGB_GRP_N];
  logic [31:0] bkt_mem [4*`FMGB_BKT_N];
  logic        take, wr, rd;

  // One wait cycle per access; writes land only on the edge at which the master sees the wait low.
  assign take        = (read | write) & ~ack_q;
  assign wr          = write & ack_q;
  assign rd          = read & ~ack_q;
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata    = rd_q;

  // Register file next state, read data and clear-on-read counters.
  always_comb begin
    ack_d      = take;
    egr_miss_d = egr_miss_q;
    trap_d     = trap_q;
    hsel_d     = hsel_q;
    tidx_d     = tidx_q;
    rd_d       = rd_q;
    elk_d      = elk_q;
    emt_d      = emt_q;
    if (rd && address == `FMGB_A_EGR_CNT) elk_d = 32'h0000_0000;
    if (rd && address == `FMGB_A_EGR_CNT + 8'h04) emt_d = 32'h0000_0000;
    if (lkp_valid && lkp.egress) begin
      elk_d = elk_d + 32'h0000_0001;
      if (lkp.hit) emt_d = emt_d + 32'h0000_0001;
    end
    for (int t = 0; t < `FMGB_IGR_TBLS; t++) begin
      igr_miss_d[t] = igr_miss_q[t];
      ilk_d[t]      = ilk_q[t];
      imt_d[t]      = imt_q[t];
      if (wr && address == `FMGB_A_IGR_MISS + 8'(4*t) && byteenable[0])
        igr_miss_d[t] = writedata[1:0];
      if (rd && address == `FMGB_A_IGR_CNT + 8'(8*t)) ilk_d[t] = 32'h0000_0000;
      if (rd && address == `FMGB_A_IGR_CNT + 8'(8*t+4)) imt_d[t] = 32'h0000_0000;
      if (lkp_valid && !lkp.egress && lkp.table_id == 2'(t)) begin
        ilk_d[t] = ilk_d[t] + 32'h0000_0001;
        if (lkp.hit) imt_d[t] = imt_d[t] + 32'h0000_0001;
      end
    end
    if (wr) begin
      case (address)
        `FMGB_A_EGR_MISS: if (byteenable[0]) egr_miss_d = writedata[0];
        `FMGB_A_TRAP:     if (byteenable[0]) trap_d = writedata[`FMGB_TRAP_BIT];
        `FMGB_A_HASH:     if (byteenable[0]) hsel_d = writedata[6:0];
        `FMGB_A_TIDX:     tidx_d = 13'(be_merge({19'h00000, tidx_q}, writedata, byteenable));
        default: ;
      endcase
    end
    if (rd) begin
      rd_d = 32'h0000_0000;
      for (int t = 0; t < `FMGB_IGR_TBLS; t++) begin
        if (address == `FMGB_A_IGR_MISS + 8'(4*t)) rd_d = {30'h0, igr_miss_q[t]};
        if (address == `FMGB_A_IGR_CNT + 8'(8*t)) rd_d = ilk_q[t];
        if (address == `FMGB_A_IGR_CNT + 8'(8*t+4)) rd_d = imt_q[t];
      end
      for (int w = 0; w < 4; w++) begin
        if (address == `FMGB_A_BKT + 8'(4*w)) rd_d = bkt_mem[{tidx_q, 2'(w)}];
      end
      case (address)
        `FMGB_A_EGR_MISS:       rd_d = {31'h0, egr_miss_q};
        `FMGB_A_TRAP:           rd_d = {25'h0, trap_q, 6'h00};
        `FMGB_A_HASH:           rd_d = {25'h0, hsel_q};
        `FMGB_A_EGR_CNT:        rd_d = elk_q;
        `FMGB_A_EGR_CNT + 8'h04: rd_d = emt_q;
        `FMGB_A_TIDX:           rd_d = {19'h0, tidx_q};
        `FMGB_A_GRP:            rd_d = {10'h000, grp_mem[tidx_q[10:0]]};
        default: ;
      endcase
    end
  end

  // Register file flip-flops; a lookup in the clearing cycle still counts.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q      <= 1'b0;
      egr_miss_q <= 1'b0;
      trap_q     <= 1'b0;
      hsel_q     <= 7'h00;
      tidx_q     <= 13'h0000;
      rd_q       <= 32'h0000_0000;
      elk_q      <= 32'h0000_0000;
      emt_q      <= 32'h0000_0000;
      for (int t = 0; t < `FMGB_IGR_TBLS; t++) begin
        igr_miss_q[t] <= 2'h0;
        ilk_q[t]      <= 32'h0000_0000;
        imt_q[t]      <= 32'h0000_0000;
      end
    end else begin
      ack_q      <= ack_d;
      egr_miss_q <= egr_miss_d;
      trap_q     <= trap_d;
      hsel_q     <= hsel_d;
      tidx_q     <= tidx_d;
      rd_q       <= rd_d;
      elk_q      <= elk_d;
      emt_q      <= emt_d;
      igr_miss_q <= igr_miss_d;
      ilk_q      <= ilk_d;
      imt_q      <= imt_d;
    end
  end

  // Table storage has no reset; software loads it before use.
  always_ff @(posedge clk) begin
    if (wr && address == `FMGB_A_GRP)
      grp_mem[tidx_q[10:0]] <= writedata[21:0];
    for (int w = 0; w < 4; w++) begin
      if (wr && address == `FMGB_A_BKT + 8'(4*w))
        bkt_mem[{tidx_q, 2'(w)}] <= be_merge(bkt_mem[{tidx_q, 2'(w)}], writedata, byteenable);
    end
  end

  fmgb_pkg::fmgb_fate_t fate_d, fate_q;
  logic                 mv_d, mv_q;

  // Miss decision, one cycle after the lookup result.
  always_comb begin
    mv_d   = lkp_valid & ~lkp.hit;
    fate_d = fmgb_pkg::FMGB_FWD;
    if (lkp.egress) begin
      fate_d = egr_miss_q ? fmgb_pkg::FMGB_DROP : fmgb_pkg::FMGB_FWD;
    end else begin
      case (igr_miss_q[lkp.table_id])
        2'h0: fate_d = fmgb_pkg::FMGB_DROP;
        2'h1: fate_d = trap_q ? fmgb_pkg::FMGB_TRAP_MST : fmgb_pkg::FMGB_TRAP_LOC;
        // Continuing past the last table is unsupported, so it drops.
        2'h2: fate_d = lkp.table_id == `FMGB_NO_NEXT_TBL ? fmgb_pkg::FMGB_DROP
                                                          : fmgb_pkg::FMGB_NEXT;
        default: fate_d = fmgb_pkg::FMGB_EXEC;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mv_q   <= 1'b0;
      fate_q <= fmgb_pkg::FMGB_FWD;
    end else begin
      mv_q   <= mv_d;
      fate_q <= fate_d;
    end
  end

  assign miss_valid    = mv_q;
  assign miss_fate     = fate_q;
  assign stop_pipeline = mv_q && fate_q == fmgb_pkg::FMGB_EXEC;

  fmgb_pkg::fmgb_state_t st_q, st_d;
  fmgb_pkg::fmgb_bucket_t ob_d, ob_q;
  logic [12:0] ptr_q, ptr_d;
  logic [7:0]  rem_q, rem_d, cnt, off;
  logic [21:0] ge;
  logic        ov_d, ov_q, ol_d, ol_q, adv;
  logic [31:0] w0, w1, w2, w3;

  assign ge        = grp_mem[grp_index];
  assign grp_ready = st_q == fmgb_pkg::FMGB_IDLE;
  assign adv       = ~ov_q | bkt_ready;
  assign w0        = bkt_mem[{ptr_q, 2'h0}];
  assign w1        = bkt_mem[{ptr_q, 2'h1}];
  assign w2        = bkt_mem[{ptr_q, 2'h2}];
  assign w3        = bkt_mem[{ptr_q, 2'h3}];
  // A count above the maximum is clamped rather than walking foreign buckets.
  assign cnt = ge[8:1] > `FMGB_MAX_BKTS ? `FMGB_MAX_BKTS : ge[8:1];
  assign off = cnt == 8'h00 ? 8'h00 : 8'({8'h00, fold(grp_key, hsel_q)} % {8'h00, cnt});

  // Group walk: All emits the range, Select one hashed bucket, both stall on the consumer.
  always_comb begin
    st_d  = st_q;
    ptr_d = ptr_q;
    rem_d = rem_q;
    ov_d  = ov_q & ~bkt_ready;
    ol_d  = ol_q;
    ob_d  = ob_q;
    case (st_q)
      fmgb_pkg::FMGB_IDLE: if (grp_valid && cnt != 8'h00) begin
        st_d = fmgb_pkg::FMGB_WALK;
        // Type bit one is Select; zero is All, which with count one is indirect.
        if (ge[0]) begin
          ptr_d = ge[21:9] + 13'(off);
          rem_d = 8'h01;
        end else begin
          ptr_d = ge[21:9];
          rem_d = cnt;
        end
      end
      fmgb_pkg::FMGB_WALK: if (adv) begin
        ov_d = 1'b1;
        ol_d = rem_q == 8'h01;
        ob_d.ttl_in            = w0[0];
        ob_d.pop_vlan          = w0[1];
        ob_d.labels_popped     = w0[2] ? (w0[3] ? 2'h2 : 2'h1) : 2'h0;
        ob_d.push_label        = w0[4];
        ob_d.push_via_encap    = w0[4] & w0[5];
        ob_d.push_ethertype    = w0[7] ? `FMGB_ETH_LBL1 : `FMGB_ETH_LBL0;
        ob_d.label_encap_index = w0[19:8];
        ob_d.ttl_out           = w0[23];
        ob_d.dec_mpls          = w0[24];
        ob_d.dec_ip            = w0[25];
        // Edits target the outermost header holding the field; the editor finds it.
        ob_d.edit_slot_a_kind  = w1[2:0];
        ob_d.edit_slot_a_data  = w1[14:3];
        ob_d.set_src_ip        = w1[17:15] == 3'h1;
        ob_d.set_dst_ip        = w1[17:15] == 3'h2;
        ob_d.new_ip            = w2;
        ob_d.set_src_port      = w1[20:18] == 3'h1;
        ob_d.set_dst_port      = w1[20:18] == 3'h2;
        ob_d.new_port          = w3[15:0];
        ob_d.set_q             = w1[21];
        ob_d.queue             = w1[24:22];
        ob_d.out_type          = w1[28:25] > `FMGB_OUT_MAX ? 4'h0 : w1[28:25];
        ob_d.out_data          = w3[31:16];
        ptr_d = ptr_q + 13'h0001;
        rem_d = rem_q - 8'h01;
        if (rem_q == 8'h01) st_d = fmgb_pkg::FMGB_IDLE;
      end
      default: st_d = fmgb_pkg::FMGB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q  <= fmgb_pkg::FMGB_IDLE;
      ptr_q <= 13'h0000;
      rem_q <= 8'h00;
      ov_q  <= 1'b0;
      ol_q  <= 1'b0;
      ob_q  <= '0;
    end else begin
      st_q  <= st_d;
      ptr_q <= ptr_d;
      rem_q <= rem_d;
      ov_q  <= ov_d;
      ol_q  <= ol_d;
      ob_q  <= ob_d;
    end
  end

  assign bkt_valid = ov_q;
  assign bkt_last  = ol_q;
  assign bkt       = ob_q;

  sequence s_igr_miss(logic [1:0] c);
    lkp_valid && !lkp.hit && !lkp.egress && igr_miss_q[lkp.table_id] == c;
  endsequence

  property p_igr_drop;
    @(posedge clk) disable iff (!rstn) s_igr_miss(2'h0) |=> miss_valid && miss_fate == fmgb_pkg::FMGB_DROP;
  endproperty
  a_igr_drop: assert property (p_igr_drop) else $error("Ingress miss did not drop.");

  property p_egr;
    @(posedge clk) disable iff (!rstn) lkp_valid && !lkp.hit && lkp.egress
      |=> miss_fate == ($past(egr_miss_q) ? fmgb_pkg::FMGB_DROP : fmgb_pkg::FMGB_FWD);
  endproperty
  a_egr: assert property (p_egr) else $error("Egress miss fate wrong.");

  property p_trap;
    @(posedge clk) disable iff (!rstn) s_igr_miss(2'h1) ##0 trap_q
      |=> miss_fate == fmgb_pkg::FMGB_TRAP_MST;
  endproperty
  a_trap: assert property (p_trap) else $error("Trap did not go to master CPU.");

  property p_exec;
    @(posedge clk) disable iff (!rstn) s_igr_miss(2'h3) |=> stop_pipeline;
  endproperty
  a_exec: assert property (p_exec) else $error("Execute set did not stop pipeline.");

  property p_pop;
    @(posedge clk) disable iff (!rstn) bkt_valid |-> bkt.labels_popped != 2'h3;
  endproperty
  a_pop: assert property (p_pop) else $error("Bad pop depth.");

  property p_eth;
    @(posedge clk) disable iff (!rstn) $rose(bkt_valid) && bkt.push_label
      |-> bkt.push_ethertype == `FMGB_ETH_LBL0 || bkt.push_ethertype == `FMGB_ETH_LBL1;
  endproperty
  a_eth: assert property (p_eth) else $error("Bad push ethertype.");

  property p_sel;
    @(posedge clk) disable iff (!rstn) grp_valid && grp_ready && ge[0] && cnt != 8'h00
      |=> rem_q == 8'h01 && st_q == fmgb_pkg::FMGB_WALK;
  endproperty
  a_sel: assert property (p_sel) else $error("Select emitted more than one bucket.");

  property p_last;
    @(posedge clk) disable iff (!rstn) st_q == fmgb_pkg::FMGB_WALK && rem_q == 8'h01 && adv
      |=> st_q == fmgb_pkg::FMGB_IDLE && bkt_valid && bkt_last;
  endproperty
  a_last: assert property (p_last) else $error("Walk did not end on its last bucket.");

  property p_off;
    @(posedge clk) disable iff (!rstn) grp_valid && cnt != 8'h00 |-> off < cnt;
  endproperty
  a_off: assert property (p_off) else $error("Select offset out of range.");

  property p_clr;
    @(posedge clk) disable iff (!rstn) rd && address == `FMGB_A_EGR_CNT && !lkp_valid
      |=> elk_q == 32'h0000_0000;
  endproperty
  a_clr: assert property (p_clr) else $error("Lookup count not cleared by read.");
endmodule

// [hw/fmgb_params.svh]
// Constants for the flow miss, group and bucket unit.
// Assumes byte addresses on a 32-bit Avalon-MM register bus.
`ifndef FMGB_PARAMS_SVH
`define FMGB_PARAMS_SVH
`define FMGB_A_IGR_MISS 8'h00
`define FMGB_A_EGR_MISS 8'h10
`define FMGB_A_TRAP     8'h14
`define FMGB_A_HASH     8'h18
`define FMGB_A_IGR_CNT  8'h20
`define FMGB_A_EGR_CNT  8'h40
`define FMGB_A_TIDX     8'h50
`define FMGB_A_GRP      8'h54
`define FMGB_A_BKT      8'h58
`define FMGB_TRAP_BIT   6
`define FMGB_IGR_TBLS   4
`define FMGB_NO_NEXT_TBL 2'h3
`define FMGB_GRP_N      2048
`define FMGB_BKT_N      8192
`define FMGB_MAX_BKTS   8'h80
`define FMGB_ETH_LBL0   16'h8847
`define FMGB_ETH_LBL1   16'h8848
`define FMGB_OUT_MAX    4'hA
`endif

// [hw/fmgb_pkg.sv]
// Types shared by the flow miss, group and bucket unit.
// Assumes the constants header is included where the numbers are needed.
package fmgb_pkg;
  typedef enum logic [2:0] {FMGB_FWD, FMGB_DROP, FMGB_TRAP_LOC, FMGB_TRAP_MST,
                            FMGB_NEXT, FMGB_EXEC} fmgb_fate_t;
  typedef enum {FMGB_IDLE, FMGB_WALK} fmgb_state_t;
  typedef struct packed {
    logic        egress;   // Lookup came from the egress table.
    logic [1:0]  table_id; // Ingress table number.
    logic        hit;      // Lookup matched an entry.
  } fmgb_lookup_t;
  typedef struct packed {
    logic [15:0] l4_dport, l4_sport;
    logic [31:0] dip, sip;
    logic [47:0] dmac, smac;
    logic [5:0]  port;
    logic [6:0]  present; // Same bit order as the hash select register.
  } fmgb_hkey_t;
  typedef struct packed {
    logic        ttl_in, ttl_out, pop_vlan, dec_mpls, dec_ip;
    logic [1:0]  labels_popped;
    logic        push_label, push_via_encap;
    logic [15:0] push_ethertype;
    logic [11:0] label_encap_index;
    logic [2:0]  edit_slot_a_kind;
    logic [11:0] edit_slot_a_data;
    logic        set_src_ip, set_dst_ip, set_src_port, set_dst_port;
    logic [31:0] new_ip;
    logic [15:0] new_port;
    logic        set_q;
    logic [2:0]  queue;
    logic [3:0]  out_type;
    logic [15:0] out_data;
  } fmgb_bucket_t;
endpackage

// [sim/fmgb_partner.sv]
// Bucket consumer standing in for the packet editing pipeline.
// Assumes one shared clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module fmgb_partner (
  input  wire logic clk,       // Shared clock.
  input  wire logic rstn,      // Reset, active low.
  input  wire logic slow,      // Stall on alternate cycles.
  input  wire logic bkt_valid, // Bucket on offer.
  output logic      bkt_ready  // Bucket taken.
);
  logic rdy_d;
  // A slow consumer drops ready after each take, so offers must survive stalls.
  always_comb begin
    rdy_d = slow ? (bkt_valid & ~bkt_ready) : 1'b1;
  end
  // Ready is registered so it never loops back on the offer combinationally.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bkt_ready <= 1'b0;
    end else begin
      bkt_ready <= rdy_d;
    end
  end
endmodule

// [sim/tb_flow_miss_group_bucket_unit.sv]
// Self-checking bench for the flow miss, group and bucket unit.
// Assumes the register map of the unit and its one-cycle register answer.
`timescale 1ns/1ps
module tb_flow_miss_group_bucket_unit;
  logic                   clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
  logic [7:0]             address = 8'h00;
  logic [31:0]            writedata = 32'h0, readdata, q, rv;
  logic [3:0]             byteenable = 4'hF;
  logic                   waitrequest, miss_valid, stop_pipeline, lkp_valid = 1'b0;
  logic                   grp_valid = 1'b0, grp_ready, bkt_valid, bkt_last, bkt_ready;
  logic                   slow = 1'b0, ev = 1'b0;
  logic [10:0]            grp_index = 11'h000;
  fmgb_pkg::fmgb_lookup_t lkp = '0;
  fmgb_pkg::fmgb_fate_t   miss_fate, ef;
  fmgb_pkg::fmgb_hkey_t   grp_key = '0, hk;
  fmgb_pkg::fmgb_bucket_t bkt;
  int                     err_count = 0, n_tests = 0, im[4], em, tb, bi, lc[5], mc[5];
  int                     exq[$];
  logic [31:0]            seed = 32'h00001A92;

  fmgb_unit fmgb_unit_inst (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .lkp_valid(lkp_valid), .lkp(lkp), .miss_valid(miss_valid), .miss_fate(miss_fate),
    .stop_pipeline(stop_pipeline), .grp_valid(grp_valid), .grp_index(grp_index), .grp_key(grp_key),
    .grp_ready(grp_ready), .bkt_valid(bkt_valid), .bkt(bkt), .bkt_last(bkt_last), .bkt_ready(bkt_ready));
  fmgb_partner fmgb_partner_inst (.clk(clk), .rstn(rstn), .slow(slow), .bkt_valid(bkt_valid),
    .bkt_ready(bkt_ready));

  // The 10 MHz clock.
  always #50 clk = ~clk;

  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One bus transfer; the request stands until the rising edge at which waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    chk(n < 20, 1'b1);
  endtask

  // Reads both words of one counter pair, then proves the read cleared the lookup count.
  task automatic rdc(input int i);
    logic [7:0] a;
    a = (i == 4) ? 8'h40 : 8'(32'h20 + 8 * i);
    bus(1'b0, a, 0);
    chk(q, lc[i]);
    bus(1'b0, a + 8'h04, 0);
    chk(q, mc[i]);
    bus(1'b0, a, 0);
    chk(q, 0);
    lc[i] = 0;
    mc[i] = 0;
  endtask

  function automatic fmgb_pkg::fmgb_fate_t xf(fmgb_pkg::fmgb_lookup_t l);
    if (l.egress) return em ? fmgb_pkg::FMGB_DROP : fmgb_pkg::FMGB_FWD;
    case (im[l.table_id])
      0: return fmgb_pkg::FMGB_DROP;
      1: return tb ? fmgb_pkg::FMGB_TRAP_MST : fmgb_pkg::FMGB_TRAP_LOC;
      2: return fmgb_pkg::FMGB_NEXT;
      default: return fmgb_pkg::FMGB_EXEC;
    endcase
  endfunction

  // Loads a group entry, predicts its bucket walk and waits for the walk to drain.
  task automatic grp(input int g, input int f, input int c, input int s, input fmgb_pkg::fmgb_hkey_t k);
    int n;
    n = 0;
    bus(1'b1, 8'h50, g);
    bus(1'b1, 8'h54, f << 9 | c << 1 | s);
    if (s) exq.push_back(f + int'(k.port) % c);
    else for (int j = 0; j < c; j++) exq.push_back(f + j);
    @(posedge clk);
    grp_valid <= 1'b1;
    grp_index <= 11'(g);
    grp_key <= k;
    @(posedge clk);
    grp_valid <= 1'b0;
    chk(grp_ready, 1'b1);
    @(posedge clk);
    chk(grp_ready, 1'b0);
    while (exq.size() != 0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(n < 300, 1'b1);
  endtask

  // Model of lookups: predicted miss answer and the two counts per table.
  always @(posedge clk) begin
    ev <= lkp_valid & ~lkp.hit & rstn;
    ef <= xf(lkp);
    if (rstn && lkp_valid) begin
      lc[lkp.egress ? 4 : int'(lkp.table_id)]++;
      if (lkp.hit) mc[lkp.egress ? 4 : int'(lkp.table_id)]++;
    end
  end

  // The miss answer stands one cycle, so it is looked at in that cycle.
  always @(negedge clk) begin
    if (rstn) begin
      chk(miss_valid, ev);
      if (ev) chk(miss_fate, ef);
      chk(stop_pipeline, ev && ef == fmgb_pkg::FMGB_EXEC);
    end
  end

  // Each bucket taken must be the next one predicted, with its fields decoded.
  always @(posedge clk) begin
    if (rstn && bkt_valid && bkt_ready) begin
      bi = exq.size() ? exq.pop_front() : -1;
      chk(bkt_last, exq.size() == 0);
      chk(bkt.out_type, bi % 11);
      chk(bkt.out_data, bi);
      chk(bkt.queue, bi % 8);
      chk(bkt.labels_popped, bi % 2 ? 2 : 1);
      chk(bkt.push_ethertype, bi / 2 % 2 ? 16'h8848 : 16'h8847);
      chk({bkt.push_via_encap, bkt.label_encap_index}, {bi / 4 % 2 == 1, 12'(bi)});
      chk(bkt.edit_slot_a_kind, bi % 8);
      chk({bkt.set_src_ip, bkt.set_dst_port, bkt.new_ip, bkt.new_port}, {2'b11, 32'(bi), 16'(bi)});
    end
  end

  task automatic print_verdict();
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog; the whole run needs about a thousand cycles.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, 8'h14, 0);
    chk(q, 0);
    for (int r = 0; r < 4; r++) begin
      for (int t = 0; t < 4; t++) begin
        im[t] = (t + r) % 4;
        if (t == 3 && im[t] == 2) im[t] = 0;
        bus(1'b1, 8'(4 * t), im[t]);
        bus(1'b0, 8'(4 * t), 0);
        chk(q, im[t]);
      end
      em = r % 2;
      tb = r / 2;
      bus(1'b1, 8'h10, em);
      bus(1'b0, 8'h10, 0);
      chk(q, em);
      bus(1'b1, 8'h14, tb << 6);
      bus(1'b0, 8'h14, 0);
      chk(q, tb << 6);
      repeat (60) begin
        rv = xs();
        @(posedge clk);
        lkp_valid <= rv[0];
        lkp <= rv[4:1];
      end
      @(posedge clk);
      lkp_valid <= 1'b0;
      for (int i = 0; i < 5; i++) rdc(i);
    end
    bus(1'b1, 8'h80, 32'hFFFFFFFF);
    bus(1'b0, 8'h80, 0);
    chk(q, 0);
    bus(1'b1, 8'h18, 32'h41);
    bus(1'b0, 8'h18, 0);
    chk(q, 32'h41);
    for (int i = 0; i < 11; i++) begin
      bus(1'b1, 8'h50, i);
      bus(1'b1, 8'h58, 32'h14 | i % 2 << 3 | i / 4 % 2 << 5 | i / 2 % 2 << 7 | i << 8);
      bus(1'b1, 8'h5C, i % 8 | i % 8 << 22 | i % 11 << 25 | 32'h88000);
      bus(1'b1, 8'h60, i);
      bus(1'b1, 8'h64, i | i << 16);
    end
    slow <= 1'b1;
    grp(0, 0, 11, 0, '0);
    slow <= 1'b0;
    grp(1, 7, 1, 0, '0);
    repeat (4) begin
      rv = xs();
      hk = '0;
      hk.l4_dport = rv[31:16];
      hk.port = rv[5:0];
      hk.sip = rv;
      hk.present = 7'h48;
      grp(2, 3, 5, 1, hk);
    end
    print_verdict();
  end
endmodule
